// >>> edd_dma.sv
`timescale 1ns/1ns
module edd_dma (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             memReq,
	output logic             memWe,
	output logic      [31:0] memAddr,
	output logic      [31:0] memWdata,
	input  wire logic [31:0] memRdata,
	input  wire logic        memAck,
	input  wire logic [12:0] rxLevel,
	input  wire logic [31:0] rxWord,
	input  wire logic        rxPktDone,
	input  wire logic [13:0] rxPktLen,
	input  wire logic [4:0]  rxPktKind,
	input  wire logic        rxPktCrcOk,
	output logic             rxPop,
	output logic             rxFrameAck,
	input  wire logic        txFifoReady,
	output logic      [31:0] txWord,
	output logic             txPush,
	output logic             txGo
);
	import edd_pkg::*;

	typedef struct packed {
		edd_state_t       st;
		edd_state_t       retSt;
		logic [1:0]       wIdx;
		logic [3:0][31:0] desc;
		logic [3:0][31:0] tdesc;
		logic [31:0]      curDesc;
		logic [31:0]      firstDesc;
		logic [31:0]      txDesc;
		logic [31:0]      bufAddr;
		logic [11:0]      space;
		logic             bufSel;
		logic             rxBusy;
		logic             multi;
		logic             txPend;
		logic             txRun;
		logic [13:0]      moved;
		logic [31:0]      rxStat;
		logic             memReq;
		logic             memWe;
		logic [31:0]      memAddr;
		logic [31:0]      memWdata;
		logic             rxPop;
		logic             rxFrameAck;
		logic [31:0]      txWord;
		logic             txPush;
		logic             txGo;
		logic [3:0]       statSet;
	} edd_dma_t;

	edd_reg_if rg ();
	edd_dma_t  r;
	edd_dma_t  n;

	edd_regs u_regs (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.ce        (ce),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rg        (rg.regs)
	);

	logic       softRst;
	logic       runtOk;
	logic       pktValid;
	logic [4:0] skip;

	assign softRst = rg.busMode[SOFT_RESET_BIT];
	assign skip = rg.busMode[SKIP_HI:SKIP_LO];
	assign runtOk = rg.netCfg[RUNT_ACCEPT_BIT];
	assign pktValid = rxPktCrcOk && |(rxPktKind & rg.netCfg[ACCEPT_HI:ACCEPT_LO]);

	// Buffer two exists only when the chain flag is low; a chained word four is a link.
	function automatic logic [11:0] edd_size2(input logic [31:0] w1);
		if (w1[CHAINED_DESC_FLAG_BIT])
			return 12'h000;
		return {1'b0, w1[BUF2_SIZE_LO +: BUF_SIZE_W]};
	endfunction : edd_size2

	function automatic logic [31:0] edd_next(input logic [31:0] cur, input logic [31:0] base,
		input logic [31:0] w1, input logic [31:0] w3, input logic [4:0] skp);
		if (w1[LAST_DESC_BIT])
			return base;
		if (w1[CHAINED_DESC_FLAG_BIT])
			return w3;
		return cur + DESC_BYTES + {25'h000_0000, skp, 2'b00};
	endfunction : edd_next

	always_comb
	begin
		n = r;
		n.rxPop = 1'b0;
		n.rxFrameAck = 1'b0;
		n.txPush = 1'b0;
		n.txGo = 1'b0;
		n.statSet = 4'h0;
		if (rg.txDemand)
			n.txPend = 1'b1;
		unique case (r.st)
			S_IDLE:
				if (rg.rxDemand)
				begin
					n.curDesc = rg.rxBase;
					n.wIdx = 2'h0;
					n.st = S_RFETCH;
				end
				else if (r.txPend)
				begin
					n.retSt = S_IDLE;
					n.st = S_TFETCH;
				end
			S_RFETCH:
				if (!r.memReq)
				begin
					n.memReq = 1'b1;
					n.memWe = 1'b0;
					n.memAddr = r.curDesc + {28'h000_0000, r.wIdx, 2'b00};
				end
				else if (memAck)
				begin
					n.memReq = 1'b0;
					n.desc[r.wIdx] = memRdata;
					n.wIdx = r.wIdx + 2'h1;
					if (r.wIdx == 2'h3)
					begin
						if (!r.desc[0][OWN_BIT])
						begin
							// Data keeps arriving in the FIFO while we wait; overflow loses it.
							n.statSet[ST_RX_UNAVAIL] = 1'b1;
							n.st = S_SUSP;
						end
						else if (r.rxBusy)
						begin
							n.bufSel = 1'b0;
							n.bufAddr = r.desc[2];
							n.space = {1'b0, r.desc[1][BUF_SIZE_W-1:0]};
							n.multi = 1'b1;
							n.st = S_RMOVE;
						end
						else
							n.st = S_RWAIT;
					end
				end
			S_SUSP:
				if (rg.rxDemand)
				begin
					n.wIdx = 2'h0;
					n.st = S_RFETCH;
				end
				else if (r.txPend)
				begin
					n.retSt = S_SUSP;
					n.st = S_TFETCH;
				end
			S_RWAIT:
				// The queue drops its done level one cycle after our acknowledge, so a frame
				// whose acknowledge is still out must not be dropped or counted twice.
				if (rxPktDone && !r.rxFrameAck && rxPktLen < 14'(MIN_FRAME_BYTES) && !runtOk)
				begin
					n.rxFrameAck = 1'b1;
					n.statSet[ST_RUNT] = 1'b1;
				end
				else if (rxPktDone && !r.rxFrameAck && !pktValid)
					n.rxFrameAck = 1'b1;
				else if (rxLevel >= MIN_FRAME_BYTES || (rxPktDone && !r.rxFrameAck && runtOk))
				begin
					n.rxBusy = 1'b1;
					n.firstDesc = r.curDesc;
					n.multi = 1'b0;
					n.moved = 14'h0000;
					n.bufSel = 1'b0;
					n.bufAddr = r.desc[2];
					n.space = {1'b0, r.desc[1][BUF_SIZE_W-1:0]};
					n.st = S_RMOVE;
				end
				else if (r.txPend)
				begin
					n.retSt = S_RWAIT;
					n.st = S_TFETCH;
				end
			S_RMOVE:
				if (r.memReq)
				begin
					if (memAck)
						n.memReq = 1'b0;
				end
				else if (rxPktDone && r.moved >= rxPktLen)
				begin
					if (pktValid)
					begin
						n.rxStat = {2'b00, rxPktLen, 11'h000, rxPktKind};
						n.st = S_RDONE1;
					end
					else
					begin
						// The first descriptor is fetched again and its data overwritten; if the packet spanned, it was released and the engine suspends.
						n.rxFrameAck = 1'b1;
						n.rxBusy = 1'b0;
						n.curDesc = r.firstDesc;
						n.wIdx = 2'h0;
						n.st = S_RFETCH;
					end
				end
				else if (r.space < WORD_BYTES)
				begin
					if (!r.bufSel && edd_size2(r.desc[1]) != 12'h000)
					begin
						n.bufSel = 1'b1;
						n.bufAddr = r.desc[3];
						n.space = edd_size2(r.desc[1]);
					end
					else
						n.st = S_RREL;
				end
				else if (rxLevel >= 13'(WORD_BYTES) || rxPktDone)
				begin
					n.rxPop = 1'b1;
					n.memReq = 1'b1;
					n.memWe = 1'b1;
					n.memAddr = r.bufAddr;
					n.memWdata = rxWord;
					n.bufAddr = r.bufAddr + 32'h0000_0004;
					n.space = r.space - WORD_BYTES;
					n.moved = r.moved + 14'h0004;
				end
			S_RREL, S_RDONE1, S_RDONE2:
				if (!r.memReq)
				begin
					n.memReq = 1'b1;
					n.memWe = 1'b1;
					n.memAddr = (r.st == S_RDONE2) ? r.firstDesc : r.curDesc;
					n.memWdata = (r.st == S_RREL) ? 32'h0000_0000 : r.rxStat;
				end
				else if (memAck)
				begin
					n.memReq = 1'b0;
					n.wIdx = 2'h0;
					if (r.st == S_RDONE1 && r.multi)
						n.st = S_RDONE2;
					else
					begin
						n.curDesc = edd_next(r.curDesc, rg.rxBase, r.desc[1], r.desc[3], skip);
						n.st = S_RFETCH;
						if (r.st != S_RREL)
						begin
							n.rxBusy = 1'b0;
							n.rxFrameAck = 1'b1;
							n.statSet[ST_RX_DONE] = 1'b1;
						end
					end
				end
			S_TFETCH:
				if (!r.memReq)
				begin
					n.memReq = 1'b1;
					n.memWe = 1'b0;
					n.memAddr = (r.txRun ? r.txDesc : rg.txBase) + {28'h000_0000, r.wIdx, 2'b00};
					n.txDesc = r.txRun ? r.txDesc : rg.txBase;
					n.txRun = 1'b1;
				end
				else if (memAck)
				begin
					n.memReq = 1'b0;
					n.tdesc[r.wIdx] = memRdata;
					n.wIdx = r.wIdx + 2'h1;
					if (r.wIdx == 2'h3)
					begin
						if (!r.tdesc[0][OWN_BIT])
						begin
							n.statSet[ST_TX_UNAVAIL] = 1'b1;
							n.txPend = 1'b0;
							n.st = r.retSt;
						end
						else
						begin
							n.bufSel = 1'b0;
							n.bufAddr = r.tdesc[2];
							n.space = {1'b0, r.tdesc[1][BUF_SIZE_W-1:0]};
							n.st = S_TCOPY;
						end
					end
				end
			S_TCOPY:
				if (r.memReq)
				begin
					if (memAck)
					begin
						n.memReq = 1'b0;
						n.txPush = 1'b1;
						n.txWord = memRdata;
						n.bufAddr = r.bufAddr + 32'h0000_0004;
						n.space = (r.space < WORD_BYTES) ? 12'h000 : r.space - WORD_BYTES;
					end
				end
				else if (r.space == 12'h000)
				begin
					if (!r.bufSel && edd_size2(r.tdesc[1]) != 12'h000)
					begin
						n.bufSel = 1'b1;
						n.bufAddr = r.tdesc[3];
						n.space = edd_size2(r.tdesc[1]);
					end
					else
						n.st = S_TWB;
				end
				else if (txFifoReady)
				begin
					n.memReq = 1'b1;
					n.memWe = 1'b0;
					n.memAddr = r.bufAddr;
				end
			S_TWB:
				if (!r.memReq)
				begin
					n.memReq = 1'b1;
					n.memWe = 1'b1;
					n.memAddr = r.txDesc;
					n.memWdata = {1'b0, r.tdesc[0][30:0]};
				end
				else if (memAck)
				begin
					n.memReq = 1'b0;
					n.txGo = 1'b1;
					n.txDesc = edd_next(r.txDesc, rg.txBase, r.tdesc[1], r.tdesc[3], skip);
					n.wIdx = 2'h0;
					n.st = S_TFETCH;
				end
			default:
				n.st = S_IDLE;
		endcase
		if (softRst)
			n = '0;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			r <= '0;
		else if (ce)
			r <= n;
	end

	assign rg.statusSet = r.statSet;
	assign rg.dmaState = r.st;
	assign memReq = r.memReq;
	assign memWe = r.memWe;
	assign memAddr = r.memAddr;
	assign memWdata = r.memWdata;
	assign rxPop = r.rxPop;
	assign rxFrameAck = r.rxFrameAck;
	assign txWord = r.txWord;
	assign txPush = r.txPush;
	assign txGo = r.txGo;

	bufOneFirst_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(r.bufSel) && r.st == S_RMOVE |-> $past(r.space) < WORD_BYTES)
		else $error("buffer two entered before buffer one was full");
	freshStart_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(r.rxBusy) |-> !r.bufSel && r.bufAddr == r.desc[2] && r.moved == 14'h0000)
		else $error("packet did not start at buffer one");
	startLevel_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(r.rxBusy) |-> $past(rxLevel >= MIN_FRAME_BYTES || (rxPktDone && runtOk)))
		else $error("receive move started too early");
	runtDrop_a: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && !softRst && r.st == S_RWAIT && rxPktDone && !r.rxFrameAck && rxPktLen < 14'h0040
		&& !runtOk
		|=> r.statSet[ST_RUNT] && r.rxFrameAck && r.st == S_RWAIT)
		else $error("runt packet not dropped");
	noBufSusp_a: assert property (@(posedge mclk) disable iff (!arst_n)
		ce && !softRst && r.st == S_RFETCH && r.memReq && memAck && r.wIdx == 2'h3
		&& !r.desc[0][OWN_BIT] |=> r.st == S_SUSP && r.statSet[ST_RX_UNAVAIL])
		else $error("missing suspend on unavailable buffer");
	release_a: assert property (@(posedge mclk) disable iff (!arst_n)
		r.st == S_RREL && r.memReq |-> r.memWe && r.memAddr == r.curDesc && !r.memWdata[OWN_BIT])
		else $error("descriptor release wrong");
	firstStat_a: assert property (@(posedge mclk) disable iff (!arst_n)
		r.st == S_RDONE2 && r.memReq |-> r.memWdata == r.rxStat && r.memAddr == r.firstDesc)
		else $error("first descriptor status differs");
	txSend_a: assert property (@(posedge mclk) disable iff (!arst_n)
		r.txGo |-> $past(r.st) == S_TWB && $past(memAck) && r.st == S_TFETCH)
		else $error("transmit request without write back");
endmodule : edd_dma

// >>> edd_pkg.sv
package edd_pkg;
	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0]  BUS_MODE_OFFSET       = 8'h00;
	localparam logic [7:0]  TX_DEMAND_OFFSET      = 8'h04;
	localparam logic [7:0]  RX_DEMAND_OFFSET      = 8'h08;
	localparam logic [7:0]  RX_LIST_BASE_OFFSET   = 8'h0c;
	localparam logic [7:0]  TX_LIST_BASE_OFFSET   = 8'h10;
	localparam logic [7:0]  STATUS_OFFSET         = 8'h14;
	localparam logic [7:0]  NETWORK_CONFIG_OFFSET = 8'h18;
	localparam logic [7:0]  DMA_STATE_OFFSET      = 8'h1c;
	localparam logic [31:0] BUS_MODE_RESET        = 32'h0000_0000;
	localparam logic [31:0] NETWORK_CONFIG_RESET  = 32'h0000_0000;
	localparam logic [31:0] LIST_BASE_RESET       = 32'h0000_0000;
	// Field positions.
	localparam int SOFT_RESET_BIT  = 0;
	localparam int SKIP_LO         = 2;
	localparam int SKIP_HI         = 6;
	localparam int ACCEPT_LO       = 3;
	localparam int ACCEPT_HI       = 7;
	localparam int RUNT_ACCEPT_BIT = 6;
	localparam int OWN_BIT         = 31;
	localparam int LAST_DESC_BIT   = 25;
	localparam int CHAINED_DESC_FLAG_BIT = 24;
	localparam int BUF2_SIZE_LO    = 11;
	localparam int BUF_SIZE_W      = 11;
	localparam int ST_RX_UNAVAIL   = 0;
	localparam int ST_RUNT         = 1;
	localparam int ST_RX_DONE      = 2;
	localparam int ST_TX_UNAVAIL   = 3;
	localparam logic [12:0] MIN_FRAME_BYTES = 13'h0040;
	localparam logic [31:0] DESC_BYTES      = 32'h0000_0010;
	localparam logic [11:0] WORD_BYTES      = 12'h004;

	typedef enum logic [3:0] {
		S_IDLE, S_RFETCH, S_RWAIT, S_RMOVE, S_RREL, S_RDONE1, S_RDONE2,
		S_SUSP, S_TFETCH, S_TCOPY, S_TWB
	} edd_state_t;
endpackage : edd_pkg

// >>> edd_reg_if.sv
`timescale 1ns/1ns
interface edd_reg_if;
	logic [31:0] busMode;
	logic [31:0] rxBase;
	logic [31:0] txBase;
	logic [31:0] netCfg;
	logic        rxDemand;
	logic        txDemand;
	logic [3:0]  statusSet;
	logic [3:0]  dmaState;
	modport regs (output busMode, rxBase, txBase, netCfg, rxDemand, txDemand,
		input statusSet, dmaState);
	modport dma (input busMode, rxBase, txBase, netCfg, rxDemand, txDemand,
		output statusSet, dmaState);
endinterface : edd_reg_if

// >>> edd_regs.sv
`timescale 1ns/1ns
module edd_regs (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	edd_reg_if.regs          rg
);
	import edd_pkg::*;

	typedef struct packed {
		logic [31:0] busMode;
		logic [31:0] rxBase;
		logic [31:0] txBase;
		logic [31:0] netCfg;
		logic [3:0]  status;
		logic        rxDemand;
		logic        txDemand;
		logic        wrPend;
		logic [7:0]  wrAddr;
		logic [31:0] rdata;
		logic        ready;
	} edd_regs_t;

	edd_regs_t r;
	edd_regs_t n;

	always_comb
	begin
		n = r;
		n.ready = 1'b1;
		n.rxDemand = 1'b0;
		n.txDemand = 1'b0;
		n.wrPend = 1'b0;
		// Soft reset is a one-cycle strobe to the engine.
		n.busMode[SOFT_RESET_BIT] = 1'b0;
		n.status = r.status | rg.statusSet;
		if (r.wrPend)
		begin
			unique case (r.wrAddr)
				BUS_MODE_OFFSET:       n.busMode = hwdata;
				TX_DEMAND_OFFSET:      n.txDemand = 1'b1;
				RX_DEMAND_OFFSET:      n.rxDemand = 1'b1;
				RX_LIST_BASE_OFFSET:   n.rxBase = hwdata;
				TX_LIST_BASE_OFFSET:   n.txBase = hwdata;
				// Write one to clear; a new event in the same cycle still sets.
				STATUS_OFFSET:         n.status = (r.status & ~hwdata[3:0]) | rg.statusSet;
				NETWORK_CONFIG_OFFSET: n.netCfg = hwdata;
				default:               n.wrPend = 1'b0;
			endcase
		end
		if (hsel && hready && htrans[1])
		begin
			n.wrPend = hwrite;
			n.wrAddr = haddr[7:0];
			unique case (haddr[7:0])
				BUS_MODE_OFFSET:       n.rdata = r.busMode;
				RX_LIST_BASE_OFFSET:   n.rdata = r.rxBase;
				TX_LIST_BASE_OFFSET:   n.rdata = r.txBase;
				STATUS_OFFSET:         n.rdata = {28'h000_0000, r.status};
				NETWORK_CONFIG_OFFSET: n.rdata = r.netCfg;
				DMA_STATE_OFFSET:      n.rdata = {28'h000_0000, rg.dmaState};
				default:               n.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			r <= '{busMode: BUS_MODE_RESET, rxBase: LIST_BASE_RESET,
				txBase: LIST_BASE_RESET, netCfg: NETWORK_CONFIG_RESET,
				ready: 1'b1, default: '0};
		else if (ce)
			r <= n;
	end

	assign hrdata = r.rdata;
	assign hreadyout = r.ready;
	assign hresp = r.ready & 1'b0;
	assign rg.busMode = r.busMode;
	assign rg.rxBase = r.rxBase;
	assign rg.txBase = r.txBase;
	assign rg.netCfg = r.netCfg;
	assign rg.rxDemand = r.rxDemand;
	assign rg.txDemand = r.txDemand;
endmodule : edd_regs

// >>> edd_host_mem.sv
`timescale 1ns/1ns
module edd_host_mem (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        slow,
	input  wire logic        memReq,
	input  wire logic        memWe,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWdata,
	output logic      [31:0] memRdata,
	output logic             memAck
);
	logic [31:0] words [0:511];
	logic [3:0]  waitCnt;

	// While no request is pending the read bus toggles, so stale data can never pass for an answer.
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			memAck <= 1'b0;
			waitCnt <= 4'h0;
			memRdata <= 32'h0000_0000;
		end
		else if (memAck)
		begin
			memAck <= 1'b0;
			memRdata <= ~memRdata;
		end
		else if (memReq && waitCnt >= (slow ? 4'h3 : 4'h0))
		begin
			memAck <= 1'b1;
			waitCnt <= 4'h0;
			if (memWe)
				words[memAddr[10:2]] <= memWdata;
			else
				memRdata <= words[memAddr[10:2]];
		end
		else if (memReq)
			waitCnt <= waitCnt + 4'h1;
		else
			memRdata <= ~memRdata;
	end
endmodule : edd_host_mem

// >>> edd_dma_tb_top.sv
`timescale 1ns/1ns
module edd_dma_tb_top;
	import edd_pkg::*;
	logic        mclk, arst_n, hsel, hwrite, hreadyout, hresp, slow, ce, txFifoReady;
	logic        memReq, memWe, memAck, rxPktDone, rxPktCrcOk, rxPop, rxFrameAck;
	logic        txPush, txGo;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, memAddr, memWdata, memRdata, txWord, rdv;
	logic [31:0] acks, gos, txCnt, miscompares, testsRun;
	logic [31:0] txSeen [0:3];
	logic [12:0] rxLevel;
	logic [13:0] rxPktLen;
	logic [4:0]  rxPktKind;
	logic [7:0]  pktTag, wIdx;
	wire  [31:0] rxWord = {pktTag, 16'h0000, wIdx};

	edd_dma uut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memReq(memReq), .memWe(memWe),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
		.rxLevel(rxLevel), .rxWord(rxWord), .rxPktDone(rxPktDone), .rxPktLen(rxPktLen),
		.rxPktKind(rxPktKind), .rxPktCrcOk(rxPktCrcOk), .rxPop(rxPop), .rxFrameAck(rxFrameAck),
		.txFifoReady(txFifoReady), .txWord(txWord), .txPush(txPush), .txGo(txGo));
	edd_host_mem host (.mclk(mclk), .arst_n(arst_n), .slow(slow), .memReq(memReq),
		.memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
		.memAck(memAck));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// The receive queue side: words leave on pops, the frame leaves on its acknowledge.
	always @(posedge mclk)
	begin
		if (rxPop)
		begin
			wIdx <= wIdx + 8'h01;
			rxLevel <= rxLevel - 13'h4;
		end
		if (rxFrameAck)
		begin
			rxPktDone <= 1'b0;
			rxLevel <= 13'h0;
			acks <= acks + 1;
		end
		if (txPush)
		begin
			txSeen[txCnt[1:0]] <= txWord;
			txCnt <= txCnt + 1;
		end
		if (txGo)
			gos <= gos + 1;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun = testsRun + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a}; hsize <= 3'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask : ahb

	task automatic frame(input logic [7:0] tag, input logic [13:0] len, input logic crc);
		@(posedge mclk);
		pktTag <= tag; wIdx <= 8'h00; rxPktLen <= len; rxPktKind <= 5'h01;
		rxPktCrcOk <= crc; rxLevel <= len[12:0]; rxPktDone <= 1'b1;
	endtask : frame

	task automatic wait_ack(input logic [31:0] n);
		for (int i = 0; i < 5000 && acks != n; i++) @(posedge mclk);
		chk("frame done", n, acks);
	endtask : wait_ack

	task automatic chk_buf(input int a, input int n, input logic [7:0] tag, input int first);
		for (int i = 0; i < n; i++)
			chk("buffer word", {tag, 16'h0000, 8'(first + i)}, host.words[(a >> 2) + i]);
	endtask : chk_buf

	task automatic t_regs;
		ahb(1'b0, BUS_MODE_OFFSET, 32'h0); chk("bus mode reset", BUS_MODE_RESET, rdv);
		ahb(1'b0, 8'h20, 32'h0); chk("unmapped read", 32'h0000_0000, rdv);
		ahb(1'b1, BUS_MODE_OFFSET, 32'h0000_0004);
		ahb(1'b1, RX_LIST_BASE_OFFSET, 32'h0000_0100);
		ahb(1'b0, RX_LIST_BASE_OFFSET, 32'h0); chk("list base", 32'h0000_0100, rdv);
		chk("okay response", 32'h0, 32'(hresp));
		$display("test regs done");
	endtask : t_regs

	task automatic t_span;
		ahb(1'b1, NETWORK_CONFIG_OFFSET, 32'h0000_00b8);
		ahb(1'b1, RX_DEMAND_OFFSET, 32'h0000_0001);
		frame(8'ha1, 14'h0040, 1'b1);
		wait_ack(1);
		chk_buf(32'h400, 4, 8'ha1, 0);
		chk_buf(32'h440, 4, 8'ha1, 4);
		chk_buf(32'h480, 8, 8'ha1, 8);
		chk("first status", 32'h0040_0001, host.words[32'h100 >> 2]);
		chk("last status", 32'h0040_0001, host.words[32'h114 >> 2]);
		ahb(1'b0, STATUS_OFFSET, 32'h0); chk("done flag", 32'h1, 32'(rdv[ST_RX_DONE]));
		$display("test span done");
	endtask : t_span

	task automatic t_runt;
		frame(8'h5a, 14'h0028, 1'b1);
		wait_ack(2);
		ahb(1'b0, STATUS_OFFSET, 32'h0); chk("runt flag", 32'h1, 32'(rdv[ST_RUNT]));
		chk("untouched desc", 32'h8000_0000, host.words[32'h200 >> 2]);
		$display("test runt done");
	endtask : t_runt

	task automatic t_reuse;
		frame(8'hbb, 14'h0040, 1'b0);
		wait_ack(3);
		ahb(1'b1, STATUS_OFFSET, 32'h0000_000f);
		ahb(1'b0, STATUS_OFFSET, 32'h0); chk("status cleared", 32'h0, rdv);
		slow <= 1'b1;
		frame(8'hcc, 14'h0054, 1'b1);
		for (int i = 0; i < 300 && rdv[ST_RX_UNAVAIL] !== 1'b1; i++) ahb(1'b0, STATUS_OFFSET, 32'h0);
		chk("unavailable flag", 32'h1, 32'(rdv[ST_RX_UNAVAIL]));
		chk("released desc", 32'h0, host.words[32'h200 >> 2]);
		host.words[32'h100 >> 2] = 32'h8000_0000;
		ahb(1'b1, RX_DEMAND_OFFSET, 32'h0000_0001);
		wait_ack(4);
		chk_buf(32'h500, 8, 8'hcc, 0);
		chk_buf(32'h540, 12, 8'hcc, 8);
		chk_buf(32'h400, 1, 8'hcc, 20);
		chk("span first", 32'h0054_0001, host.words[32'h200 >> 2]);
		chk("span last", 32'h0054_0001, host.words[32'h100 >> 2]);
		$display("test reuse done");
	endtask : t_reuse

	task automatic t_tx;
		host.words[32'h580 >> 2] = 32'h8000_0000;
		host.words[32'h584 >> 2] = 32'h0100_0008;
		host.words[32'h588 >> 2] = 32'h0000_05c0;
		host.words[32'h58c >> 2] = 32'h0000_05a0;
		host.words[32'h5c0 >> 2] = 32'h7e57_0000;
		host.words[32'h5c4 >> 2] = 32'h7e57_0001;
		ahb(1'b1, TX_LIST_BASE_OFFSET, 32'h0000_0580);
		ahb(1'b1, TX_DEMAND_OFFSET, 32'h0000_0001);
		for (int i = 0; i < 2000 && gos == 0; i++) @(posedge mclk);
		chk("go pulses", 32'h1, gos);
		chk("pushes", 32'h2, txCnt);
		chk("tx word0", 32'h7e57_0000, txSeen[0]);
		chk("tx word1", 32'h7e57_0001, txSeen[1]);
		chk("tx owner", 32'h0, 32'(host.words[32'h580 >> 2][OWN_BIT]));
		$display("test tx done");
	endtask : t_tx

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	initial
	begin
		#(8 * 60000);
		miscompares = miscompares + 1;
		wrap_up();
	end

	initial
	begin
		arst_n = 1'b0; ce = 1'b1; txFifoReady = 1'b1; slow = 1'b0;
		hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
		rxLevel = 13'h0; rxPktDone = 1'b0; rxPktLen = 14'h0; rxPktKind = 5'h0; rxPktCrcOk = 1'b0;
		pktTag = 8'h00; wIdx = 8'h00; acks = 0; gos = 0; txCnt = 0; miscompares = 0; testsRun = 0;
		for (int i = 0; i < 512; i++) host.words[i] = 32'h0;
		// Mixed list: skipping entry, chained entry, last entry holding two buffers.
		host.words[32'h100 >> 2] = 32'h8000_0000;
		host.words[32'h104 >> 2] = 32'h0000_8010;
		host.words[32'h108 >> 2] = 32'h0000_0400;
		host.words[32'h10c >> 2] = 32'h0000_0440;
		host.words[32'h114 >> 2] = 32'h8000_0000;
		host.words[32'h118 >> 2] = 32'h0100_0040;
		host.words[32'h11c >> 2] = 32'h0000_0480;
		host.words[32'h120 >> 2] = 32'h0000_0200;
		host.words[32'h200 >> 2] = 32'h8000_0000;
		host.words[32'h204 >> 2] = 32'h0201_8020;
		host.words[32'h208 >> 2] = 32'h0000_0500;
		host.words[32'h20c >> 2] = 32'h0000_0540;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		t_regs();
		t_span();
		t_runt();
		t_reuse();
		t_tx();
		wrap_up();
	end
endmodule : edd_dma_tb_top
